//--- rtl/uhpc_ctrl.sv
`timescale 1ns/1ps
module uhpc_ctrl
  import uhpc_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // host bus
  input wire uhpc_pkg::uhpc_bus_t i_bus,
  input wire logic i_bus_style_sel,
  input wire logic i_reset_pin,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_int_out,
  output logic o_int_oe,
  // power control
  input wire logic i_power_save_isolate_in,
  input wire logic i_charge_pump_autosleep_in,
  input wire logic i_osc_stopped,
  output logic o_charge_pump_on,
  output logic o_dev_reset,
  // serial
  input wire logic i_rx_serial,
  output logic o_tx_serial
);
  logic dev_rst, rd_act, wr_act, rd_act_q, wr_act_q, rd_end, wr_end;
  logic [2:0] addr_q;
  logic [7:0] wdata_q, irq_en_q, div_lo_q, div_hi_q, mcr_q, scratch_q;
  logic tx_empty, tx_full, rx_empty, rx_full, tx_pop, rx_push, irq;
  logic [7:0] tx_head, rx_head;
  logic [1:0] pre_q;
  logic pre_tick, tick16;
  logic [DIV_W-1:0] div_cnt_q, div_val;
  uhpc_ser_state_t tx_st_q, rx_st_q;
  logic [3:0] tx_cnt_q, rx_cnt_q;
  logic [2:0] tx_bit_q, rx_bit_q;
  logic [7:0] tx_sh_q, rx_sh_q;
  logic [7:0] o_data_q, status;
  logic o_data_oe_q, o_int_out_q, o_int_oe_q, o_cp_on_q, o_dev_reset_q, o_tx_q;

  // reset pin polarity follows the bus style
  function automatic logic pin_reset(input logic style, input logic lvl);
    return style ? lvl : !lvl;
  endfunction

  // register read decode
  function automatic logic [7:0] reg_read(input logic [2:0] a, input logic [7:0] st);
    unique case (a)
      ADDR_DATA: return rx_head;
      ADDR_IRQ_EN: return irq_en_q;
      ADDR_STATUS: return st;
      ADDR_DIV_LO: return div_lo_q;
      ADDR_DIV_HI: return div_hi_q;
      ADDR_MODEM_CTL: return mcr_q;
      ADDR_SCRATCH: return scratch_q;
      default: return BYTE_ZERO;
    endcase
  endfunction

  // combined device reset
  assign dev_rst = !i_rst_n || pin_reset(i_bus_style_sel, i_reset_pin);

  // bus decode, gated off while isolated
  assign wr_act = !i_power_save_isolate_in && !i_bus.cs_n && !i_bus.write_strobe_n;
  assign rd_act = !i_power_save_isolate_in && !i_bus.cs_n
    && (i_bus_style_sel ? !i_bus.read_strobe_n : i_bus.write_strobe_n);
  assign wr_end = wr_act_q && !wr_act && !i_power_save_isolate_in;
  assign rd_end = rd_act_q && !rd_act && !i_power_save_isolate_in;

  // cycle tracking and write data capture
  always_ff @(posedge i_mclk) begin
    if (dev_rst) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      addr_q <= ADDR_DATA;
      wdata_q <= BYTE_ZERO;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act || rd_act) begin
        addr_q <= i_bus.addr;
      end
      if (wr_act) begin
        wdata_q <= i_bus.data;
      end
    end
  end

  // configuration registers
  always_ff @(posedge i_mclk) begin
    if (dev_rst) begin
      irq_en_q <= IRQ_EN_RST;
      div_lo_q <= DIV_LO_RST;
      div_hi_q <= DIV_HI_RST;
      mcr_q <= MODEM_CTL_RST;
      scratch_q <= SCRATCH_RST;
    end else if (wr_end) begin
      unique case (addr_q)
        ADDR_IRQ_EN: irq_en_q <= wdata_q;
        ADDR_DIV_LO: div_lo_q <= wdata_q;
        ADDR_DIV_HI: div_hi_q <= wdata_q;
        ADDR_MODEM_CTL: mcr_q <= wdata_q;
        ADDR_SCRATCH: scratch_q <= wdata_q;
        default: ;
      endcase
    end
  end

  // transmit and receive fifos
  uhpc_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_tx_fifo (
    .i_mclk(i_mclk), .i_clr(dev_rst),
    .i_push(wr_end && addr_q == ADDR_DATA), .i_data(wdata_q), .o_full(tx_full),
    .i_pop(tx_pop), .o_data(tx_head), .o_empty(tx_empty)
  );
  uhpc_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_rx_fifo (
    .i_mclk(i_mclk), .i_clr(dev_rst),
    .i_push(rx_push), .i_data(rx_sh_q), .o_full(rx_full),
    .i_pop(rd_end && addr_q == ADDR_DATA), .o_data(rx_head), .o_empty(rx_empty)
  );

  // prescaler and divisor give the sampling tick
  assign pre_tick = !mcr_q[MCR_PRESCALE_BIT] || (pre_q == PRESCALE_LAST);
  assign div_val = {div_hi_q, div_lo_q};
  assign tick16 = pre_tick && (div_cnt_q + 1'b1 >= div_val);
  always_ff @(posedge i_mclk) begin
    if (dev_rst) begin
      pre_q <= '0;
      div_cnt_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
      if (tick16) begin
        div_cnt_q <= '0;
      end else if (pre_tick) begin
        div_cnt_q <= div_cnt_q + 1'b1;
      end
    end
  end

  // transmitter, 8 data bits with one start and one stop bit
  assign tx_pop = tick16 && tx_st_q == SER_IDLE && !tx_empty;
  always_ff @(posedge i_mclk) begin
    if (dev_rst) begin
      tx_st_q <= SER_IDLE;
      tx_cnt_q <= SAMPLE_ZERO;
      tx_bit_q <= BIT_ZERO;
      tx_sh_q <= BYTE_ZERO;
      o_tx_q <= 1'b1;
    end else if (tick16) begin
      tx_cnt_q <= tx_cnt_q + 1'b1;
      unique case (tx_st_q)
        SER_IDLE: begin
          tx_cnt_q <= SAMPLE_ZERO;
          if (!tx_empty) begin
            tx_sh_q <= tx_head;
            tx_st_q <= SER_START;
            o_tx_q <= 1'b0;
          end
        end
        SER_START: if (tx_cnt_q == SAMPLE_LAST) begin
          tx_st_q <= SER_DATA;
          tx_bit_q <= BIT_ZERO;
          o_tx_q <= tx_sh_q[0];
        end
        SER_DATA: if (tx_cnt_q == SAMPLE_LAST) begin
          tx_bit_q <= tx_bit_q + 1'b1;
          tx_sh_q <= {1'b0, tx_sh_q[7:1]};
          o_tx_q <= (tx_bit_q == BIT_LAST) ? 1'b1 : tx_sh_q[1];
          if (tx_bit_q == BIT_LAST) begin
            tx_st_q <= SER_STOP;
          end
        end
        SER_STOP: if (tx_cnt_q == SAMPLE_LAST) begin
          tx_st_q <= SER_IDLE;
        end
      endcase
    end
  end

  // receiver, start bit checked at mid-bit, data sampled one bit later
  assign rx_push = tick16 && rx_st_q == SER_STOP && rx_cnt_q == SAMPLE_LAST
    && i_rx_serial && !rx_full;
  always_ff @(posedge i_mclk) begin
    if (dev_rst) begin
      rx_st_q <= SER_IDLE;
      rx_cnt_q <= SAMPLE_ZERO;
      rx_bit_q <= BIT_ZERO;
      rx_sh_q <= BYTE_ZERO;
    end else if (tick16) begin
      rx_cnt_q <= rx_cnt_q + 1'b1;
      unique case (rx_st_q)
        SER_IDLE: begin
          rx_cnt_q <= SAMPLE_ZERO;
          if (!i_rx_serial) begin
            rx_st_q <= SER_START;
          end
        end
        SER_START: if (rx_cnt_q == SAMPLE_MID) begin
          rx_cnt_q <= SAMPLE_ZERO;
          rx_bit_q <= BIT_ZERO;
          rx_st_q <= i_rx_serial ? SER_IDLE : SER_DATA;
        end
        SER_DATA: if (rx_cnt_q == SAMPLE_LAST) begin
          rx_sh_q <= {i_rx_serial, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 1'b1;
          if (rx_bit_q == BIT_LAST) begin
            rx_st_q <= SER_STOP;
          end
        end
        SER_STOP: if (rx_cnt_q == SAMPLE_LAST) begin
          rx_st_q <= SER_IDLE;
        end
      endcase
    end
  end

  // pending interrupt sources
  assign irq = (irq_en_q[IER_RX_BIT] && !rx_empty) || (irq_en_q[IER_TX_BIT] && tx_empty);
  assign status = {5'h00, tx_full, tx_empty, !rx_empty};

  // registered outputs
  always_ff @(posedge i_mclk) begin
    if (dev_rst) begin
      o_data_q <= BYTE_ZERO;
      o_data_oe_q <= 1'b0;
      o_int_out_q <= 1'b0;
      o_int_oe_q <= 1'b0;
    end else begin
      o_data_q <= rd_act ? reg_read(i_bus.addr, status) : BYTE_ZERO;
      o_data_oe_q <= rd_act;
      o_int_out_q <= i_bus_style_sel && irq;
      o_int_oe_q <= i_bus_style_sel ? mcr_q[MCR_IRQ_OE_BIT] : irq;
    end
  end

  // power and reset indicators
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_cp_on_q <= 1'b1;
      o_dev_reset_q <= 1'b1;
    end else begin
      o_cp_on_q <= !(i_charge_pump_autosleep_in && i_osc_stopped);
      o_dev_reset_q <= dev_rst;
    end
  end

  assign o_data = o_data_q;
  assign o_data_oe = o_data_oe_q;
  assign o_int_out = o_int_out_q;
  assign o_int_oe = o_int_oe_q;
  assign o_charge_pump_on = o_cp_on_q;
  assign o_dev_reset = o_dev_reset_q;
  assign o_tx_serial = o_tx_q;

  property p_isolate_no_drive;
    @(posedge i_mclk) disable iff (!i_rst_n) i_power_save_isolate_in |=> !o_data_oe;
  endproperty
  a_isolate_no_drive: assert property (p_isolate_no_drive) else $error("bus driven while isolated");
  property p_cp_off;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_charge_pump_autosleep_in && i_osc_stopped |=> !o_charge_pump_on;
  endproperty
  a_cp_off: assert property (p_cp_off) else $error("charge pump not turned off");
  property p_cp_on;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !(i_charge_pump_autosleep_in && i_osc_stopped) |=> o_charge_pump_on;
  endproperty
  a_cp_on: assert property (p_cp_on) else $error("charge pump off without cause");
  property p_reset_polarity;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_bus_style_sel == i_reset_pin) [*1] |=> o_dev_reset && o_tx_serial;
  endproperty
  a_reset_polarity: assert property (p_reset_polarity) else $error("reset pin not honoured");
  property p_reset_defaults;
    @(posedge i_mclk) dev_rst |=> div_lo_q == DIV_LO_RST && mcr_q == MODEM_CTL_RST && tx_empty;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("register not at default");
  property p_reset_tx_idle;
    @(posedge i_mclk) dev_rst [*2] |-> o_tx_serial && !o_data_oe && !o_int_oe;
  endproperty
  a_reset_tx_idle: assert property (p_reset_tx_idle) else $error("outputs active in reset");
  property p_dir_ignores_rd;
    @(posedge i_mclk) disable iff (dev_rst)
      !i_bus_style_sel && !i_power_save_isolate_in && !i_bus.cs_n && !i_bus.write_strobe_n
      |=> !o_data_oe;
  endproperty
  a_dir_ignores_rd: assert property (p_dir_ignores_rd) else $error("read during write cycle");
  property p_write_on_rise;
    @(posedge i_mclk) disable iff (dev_rst)
      wr_end && addr_q == ADDR_SCRATCH |=> scratch_q == $past(wdata_q);
  endproperty
  a_write_on_rise: assert property (p_write_on_rise) else $error("write not stored");
  property p_irq_style;
    @(posedge i_mclk) disable iff (dev_rst)
      !i_bus_style_sel |=> !o_int_out && (o_int_oe == $past(irq));
  endproperty
  a_irq_style: assert property (p_irq_style) else $error("open drain irq wrong");
  property p_irq_strobe;
    @(posedge i_mclk) disable iff (dev_rst)
      i_bus_style_sel |=> o_int_oe == $past(mcr_q[MCR_IRQ_OE_BIT]) && o_int_out == $past(irq);
  endproperty
  a_irq_strobe: assert property (p_irq_strobe) else $error("strobe irq wrong");
  property p_tx_start_bit;
    @(posedge i_mclk) disable iff (dev_rst) tx_pop |=> !o_tx_serial;
  endproperty
  a_tx_start_bit: assert property (p_tx_start_bit) else $error("no start bit");
  c_write: cover property (@(posedge i_mclk) wr_end);
  c_rx_byte: cover property (@(posedge i_mclk) rx_push);
  c_tx_full: cover property (@(posedge i_mclk) tx_full);
  c_isolated_cycle: cover property (@(posedge i_mclk) i_power_save_isolate_in && !i_bus.cs_n);
endmodule // uhpc_ctrl

//--- rtl/uhpc_fifo.sv
`timescale 1ns/1ps
module uhpc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and clear
  input wire logic i_mclk,
  input wire logic i_clr,
  // fill side
  input wire logic i_push,
  input wire logic [W-1:0] i_data,
  output logic o_full,
  // drain side
  input wire logic i_pop,
  output logic [W-1:0] o_data,
  output logic o_empty
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH = (AW+1)'(D); // full count needs the extra bit

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  // pushes into a full fifo and pops from an empty one are dropped
  assign do_push = i_push && (cnt_q != DEPTH);
  assign do_pop = i_pop && (cnt_q != '0);
  assign o_full = (cnt_q == DEPTH);
  assign o_empty = (cnt_q == '0);
  assign o_data = mem[rd_q];

  // storage
  always_ff @(posedge i_mclk) begin
    if (do_push) begin
      mem[wr_q] <= i_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge i_mclk) begin
    if (i_clr) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // uhpc_fifo

//--- rtl/uhpc_pkg.sv
package uhpc_pkg;
  // widths and depths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int DIV_W = 16;

  // register addresses
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IRQ_EN = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_DIV_LO = 3'h3;
  localparam logic [2:0] ADDR_DIV_HI = 3'h4;
  localparam logic [2:0] ADDR_MODEM_CTL = 3'h5;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;

  // reset values
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] DIV_LO_RST = 8'h01;
  localparam logic [7:0] DIV_HI_RST = 8'h00;
  localparam logic [7:0] MODEM_CTL_RST = 8'h00;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // field positions
  localparam int MCR_IRQ_OE_BIT = 3;
  localparam int MCR_PRESCALE_BIT = 7;
  localparam int IER_RX_BIT = 0;
  localparam int IER_TX_BIT = 1;
  localparam int STAT_RX_AVAIL_BIT = 0;
  localparam int STAT_TX_EMPTY_BIT = 1;
  localparam int STAT_TX_FULL_BIT = 2;

  // sampling and prescale counts
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [3:0] SAMPLE_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [3:0] SAMPLE_ZERO = 4'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ZERO = 3'h0;

  // reset pulse timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_MIN_NS = 40;
  localparam int RESET_MIN_RAW = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_MIN_CYC = (RESET_MIN_RAW < 1) ? 1 : RESET_MIN_RAW;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_START = 2'b01,
    SER_DATA = 2'b10,
    SER_STOP = 2'b11
  } uhpc_ser_state_t;

  typedef struct packed {
    logic cs_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [2:0] addr;
    logic [7:0] data;
  } uhpc_bus_t;
endpackage

//--- tb/test_uart_host_bus_reset_power_ctrl.sv
`timescale 1ns/1ps
module test_uart_host_bus_reset_power_ctrl;
  import uhpc_pkg::*;
  // bench signals
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b1;
  logic rpin = 1'b0;
  logic ps = 1'b0;
  logic asl = 1'b0;
  logic osc = 1'b0;
  logic loop = 1'b0;
  logic junk = 1'b1;
  uhpc_bus_t bus;
  logic [7:0] rdata;
  logic data_oe, int_out, int_oe, cp_on, dev_rst, tx;
  int err_total = 0;
  int checked = 0;
  integer seed = 32'hc08c;
  logic [7:0] exp_q[$];
  logic oe_prev = 1'b0;
  logic [7:0] d;
  logic [2:0] ra [6] = '{ADDR_DIV_LO, ADDR_DIV_HI, ADDR_MODEM_CTL, ADDR_IRQ_EN,
    ADDR_SCRATCH, ADDR_STATUS};
  logic [7:0] rv [6] = '{DIV_LO_RST, DIV_HI_RST, MODEM_CTL_RST, IRQ_EN_RST,
    SCRATCH_RST, 8'h02};

  // clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  uhpc_host_model hbm_u (.i_mclk(mclk), .i_bus_style_sel(sel), .i_junk(junk), .o_bus(bus));

  uhpc_ctrl dut_u (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_bus(bus), .i_bus_style_sel(sel), .i_reset_pin(rpin),
    .o_data(rdata), .o_data_oe(data_oe), .o_int_out(int_out), .o_int_oe(int_oe),
    .i_power_save_isolate_in(ps), .i_charge_pump_autosleep_in(asl), .i_osc_stopped(osc),
    .o_charge_pump_on(cp_on), .o_dev_reset(dev_rst),
    .i_rx_serial(loop ? tx : 1'b1), .o_tx_serial(tx));

  // noise on the read strobe, ignored in direction style
  always @(negedge mclk) begin
    junk <= 1'($random(seed));
  end

  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s: expected %h, seen %h", nm, e, s);
    end
  endtask

  task automatic cmp1(input string nm, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s: expected %b, seen %b", nm, e, s);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // note the expected byte, then read
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    hbm_u.rd(a);
    repeat (2) @(negedge mclk);
  endtask

  // style change moves the reset pin to its inactive level too
  task automatic style(input logic s);
    @(negedge mclk);
    sel = s;
    rpin = ~s;
    repeat (2) @(negedge mclk);
  endtask

  // low time of a start bit on the transmit line
  task automatic meas(input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 100 && tx !== 1'b0; i++) @(negedge mclk);
    while (tx === 1'b0 && n < 8'hc8) begin
      @(negedge mclk);
      n++;
    end
    cmp8("start bit cycles", e, n);
  endtask

  // read data monitor: each rise of the enable takes the oldest note
  always @(negedge mclk) begin
    if (data_oe === 1'b1 && oe_prev !== 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("[ERR] read data: expected none, seen %h", rdata);
      end else begin
        cmp8("read data", exp_q.pop_front(), rdata);
      end
    end
    oe_prev = data_oe;
  end

  // main sequence
  initial begin
    repeat (11) @(negedge mclk);
    cmp1("tx in reset", 1'b1, tx);
    cmp1("device reset", 1'b1, dev_rst);
    cmp1("oe in reset", 1'b0, data_oe);
    @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
    for (int s = 1; s >= 0; s--) begin
      style(s[0]);
      d = 8'($random(seed));
      hbm_u.wr(ADDR_SCRATCH, d);
      hbm_u.wr(3'h6, ~d);
      rd(ADDR_SCRATCH, d);
      // isolated bus: no write taken, no read answered
      ps = 1'b1;
      hbm_u.wr(ADDR_SCRATCH, ~d);
      hbm_u.rd(ADDR_SCRATCH);
      cmp1("isolated oe", 1'b0, data_oe);
      ps = 1'b0;
      rd(ADDR_SCRATCH, d);
      // reset pin at the level this style treats as active
      rpin = s[0];
      repeat (2) @(negedge mclk);
      cmp1("pin reset", 1'b1, dev_rst);
      cmp1("tx in pin reset", 1'b1, tx);
      rpin = ~s[0];
      @(negedge mclk);
      rd(ADDR_SCRATCH, SCRATCH_RST);
      // interrupt pin style
      hbm_u.wr(ADDR_IRQ_EN, 8'h02);
      hbm_u.wr(ADDR_MODEM_CTL, {4'h0, s[0], 3'h0});
      repeat (2) @(negedge mclk);
      cmp1("irq out", s[0], int_out);
      cmp1("irq oe", 1'b1, int_oe);
      hbm_u.wr(ADDR_MODEM_CTL, MODEM_CTL_RST);
      repeat (2) @(negedge mclk);
      cmp1("irq oe off", ~s[0], int_oe);
      hbm_u.wr(ADDR_IRQ_EN, IRQ_EN_RST);
    end
    // charge pump over all input pairs
    for (int i = 0; i < 4; i++) begin
      {asl, osc} = i[1:0];
      repeat (2) @(negedge mclk);
      cmp1("charge pump", ~(asl & osc), cp_on);
    end
    {asl, osc} = 2'b00;
    // serial loopback at both prescale settings
    style(1'b1);
    loop = 1'b1;
    for (int p = 0; p < 2; p++) begin
      hbm_u.wr(ADDR_MODEM_CTL, {p[0], 7'h00});
      hbm_u.wr(ADDR_DATA, 8'hff);
      meas(p[0] ? 8'h40 : 8'h10);
      repeat (800) @(negedge mclk);
      rd(ADDR_DATA, 8'hff);
    end
    hbm_u.wr(ADDR_MODEM_CTL, MODEM_CTL_RST);
    d = 8'($random(seed));
    hbm_u.wr(ADDR_DATA, d);
    repeat (200) @(negedge mclk);
    rd(ADDR_STATUS, 8'h03);
    // receive-available interrupt follows the rx fifo
    hbm_u.wr(ADDR_IRQ_EN, 8'h01);
    repeat (2) @(negedge mclk);
    cmp1("rx irq", 1'b1, int_out);
    rd(ADDR_DATA, d);
    cmp1("rx irq clear", 1'b0, int_out);
    rd(ADDR_STATUS, 8'h02);
    // fill the transmit queue past its depth on a slow line
    loop = 1'b0;
    hbm_u.wr(ADDR_DIV_HI, 8'hff);
    repeat (17) hbm_u.wr(ADDR_DATA, 8'($random(seed)));
    rd(ADDR_STATUS, 8'h04);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    rd(ADDR_STATUS, 8'h02);
    rd(ADDR_DIV_HI, DIV_HI_RST);
    cmp8("pending reads", 8'h00, 8'(exp_q.size()));
    complete_run();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    complete_run();
  end
endmodule // test_uart_host_bus_reset_power_ctrl

//--- tb/uhpc_host_model.sv
`timescale 1ns/1ps
module uhpc_host_model (
  // clock and bus style
  input wire logic i_mclk,
  input wire logic i_bus_style_sel,
  input wire logic i_junk,
  // host bus pins
  output uhpc_pkg::uhpc_bus_t o_bus
);
  import uhpc_pkg::*;
  logic [7:0] last_q = 8'h00;

  // parked bus: deselected, released lines stop showing old values
  task automatic idle();
    o_bus.cs_n = 1'b1;
    o_bus.write_strobe_n = 1'b1;
    o_bus.read_strobe_n = i_bus_style_sel ? 1'b1 : i_junk;
    o_bus.data = ~last_q;
    o_bus.addr = ~o_bus.addr;
  endtask

  // start parked
  initial begin
    o_bus = '1;
  end

  // one write: strobe style ends on strobe rise, direction style on select rise
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    last_q = d;
    o_bus.cs_n = 1'b0;
    o_bus.write_strobe_n = 1'b0;
    o_bus.addr = a;
    o_bus.data = d;
    @(negedge i_mclk);
    if (i_bus_style_sel) begin
      o_bus.write_strobe_n = 1'b1;
    end else begin
      o_bus.cs_n = 1'b1;
    end
    @(negedge i_mclk);
    idle();
  endtask

  // one read held over two edges; rw stays high in direction style
  task automatic rd(input logic [2:0] a);
    @(negedge i_mclk);
    o_bus.cs_n = 1'b0;
    o_bus.addr = a;
    o_bus.data = ~o_bus.data;
    if (i_bus_style_sel) begin
      o_bus.read_strobe_n = 1'b0;
    end
    repeat (2) @(negedge i_mclk);
    idle();
  endtask
endmodule // uhpc_host_model
